// ===== verilog/perf_monitor_pkg.sv
// constants shared by the performance-monitor counter block
package perf_monitor_pkg;

	// ****************************************************************
	// register offsets on the microprocessor port
	// ****************************************************************
	localparam logic [7:0] CTRL_STATUS_ADDR  = 8'h48; // perf_monitor_control_status
	localparam logic [7:0] FER_COUNT_ADDR    = 8'h49; // framing_bit_error_count
	localparam logic [7:0] FEBE_LOW_ADDR     = 8'h4a; // far_block_error_count_low
	localparam logic [7:0] FEBE_HIGH_ADDR    = 8'h4b; // far_block_error_count_high
	localparam logic [7:0] CRC_LOW_ADDR      = 8'h4c; // crc_error_count_low
	localparam logic [7:0] CRC_HIGH_ADDR     = 8'h4d; // crc_error_count_high
	localparam logic [7:0] LCV_LOW_ADDR      = 8'h4e; // line_code_violation_count_low
	localparam logic [7:0] LCV_HIGH_ADDR     = 8'h4f; // line_code_violation_count_high

	// ****************************************************************
	// control/status field positions and reset values
	// ****************************************************************
	localparam int         IRQ_EN_BIT        = 2;
	localparam int         TRANSFER_DONE_FLAG_BIT          = 1;
	localparam int         OVR_BIT           = 0;
	localparam logic       IRQ_EN_RST        = 1'b0;
	localparam logic       TRANSFER_DONE_FLAG_RST          = 1'b0;
	localparam logic       OVR_RST           = 1'b0;
	localparam logic [7:0] RDATA_RST         = 8'h00;

	// ****************************************************************
	// counter widths and revision field width
	// ****************************************************************
	localparam int         FER_W             = 7;
	localparam int         FEBE_W            = 10;
	localparam int         CRC_W             = 10;
	localparam int         LCV_W             = 13;
	localparam int         REV_W             = 7;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int         MCLK_PERIOD_NS    = 10;
	// latest load of the holding registers, in high-speed reference periods
	localparam int         LATCH_MAX_PERIODS = 27;
	// software should wait this long after the latching write before reading
	localparam int         READ_WAIT_NS      = 1700;
	localparam int         READ_WAIT_CYCLES  = (READ_WAIT_NS + MCLK_PERIOD_NS - 1)
	                                           / MCLK_PERIOD_NS;

endpackage : perf_monitor_pkg

// ===== verilog/perf_monitor.sv
// performance-monitor event counters with holding registers and status
`timescale 1ns/1ns

// ****************************************************************
// one saturating event counter with its holding register
// ****************************************************************
module perf_event_counter #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// event side
	input  wire logic         event_pulse,
	input  wire logic         count_ok,
	// latch request
	input  wire logic         latch,
	// values
	output logic [W-1:0]      live_r,
	output logic [W-1:0]      held_r
);
	logic [W-1:0] live_nxt;
	logic         take;
	logic         full;

	// an event that lands in the latch cycle opens the new interval
	assign take = event_pulse & count_ok;
	assign full = &live_r;
	assign live_nxt = latch ? {{(W-1){1'b0}}, take} :
	                  (take && !full) ? live_r + {{(W-1){1'b0}}, 1'b1} :
	                  live_r;

	// live count and holding copy
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			live_r <= '0;
			held_r <= '0;
		end else begin
			live_r <= live_nxt;
			if (latch) begin
				held_r <= live_r;
			end
		end
	end
endmodule : perf_event_counter

// ****************************************************************
// block top
// ****************************************************************
module perf_monitor #(
	// early-silicon identification value; this default is arbitrary
	parameter logic [6:0] EARLY_REV_ID = 7'h55
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// microprocessor register port
	input  wire logic [7:0]   reg_addr,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [7:0]   reg_wdata,
	output logic [7:0]        reg_rdata_r,
	// events from the frame_aligner and line decoder
	input  wire logic         fer_event,
	input  wire logic         febe_event,
	input  wire logic         crc_event,
	input  wire logic         lcv_event,
	input  wire logic         frame_lost,
	input  wire logic         crc_multiframe_lost,
	// revision register field
	input  wire logic [6:0]   chip_revision_field,
	// interrupt
	output logic              interrupt_request_n
);
	localparam int FW = perf_monitor_pkg::FER_W;
	localparam int BW = perf_monitor_pkg::FEBE_W;
	localparam int CW = perf_monitor_pkg::CRC_W;
	localparam int LW = perf_monitor_pkg::LCV_W;
	localparam int LATCH_LIMIT = perf_monitor_pkg::LATCH_MAX_PERIODS;

	logic [FW-1:0] fer_live;
	logic [FW-1:0] fer_hold;
	logic [BW-1:0] febe_live;
	logic [BW-1:0] febe_hold;
	logic [CW-1:0] crc_live;
	logic [CW-1:0] crc_hold;
	logic [LW-1:0] lcv_live;
	logic [LW-1:0] lcv_hold;

	logic          irq_on_latch_en_r;
	logic          transfer_done_flag_r;
	logic          holding_overrun_flag_r;
	logic          irq_en_nxt;
	logic          transfer_done_flag_nxt;
	logic          ovr_nxt;

	logic          count_addr;
	logic          latch_now;
	logic          status_rd;
	logic          status_wr;
	logic          irq_supported;
	logic [7:0]    status_byte;
	logic [7:0]    rdata_nxt;

	// ****************************************************************
	// address decode
	// ****************************************************************
	// one write strobe latches everything; a second write in the same poll
	// starts a fresh interval, so software must write one address only
	assign count_addr = (reg_addr >= perf_monitor_pkg::FER_COUNT_ADDR) &&
	                    (reg_addr <= perf_monitor_pkg::LCV_HIGH_ADDR);
	assign latch_now  = reg_wr && count_addr;
	assign status_rd  = reg_rd && (reg_addr == perf_monitor_pkg::CTRL_STATUS_ADDR);
	assign status_wr  = reg_wr && (reg_addr == perf_monitor_pkg::CTRL_STATUS_ADDR);
	assign irq_supported = (chip_revision_field != EARLY_REV_ID);

	// ****************************************************************
	// the four counters
	// ****************************************************************
	perf_event_counter #(.W(FW)) u_fer (
		.mclk        (mclk),
		.resetn      (resetn),
		.event_pulse (fer_event),
		.count_ok    (!frame_lost),
		.latch       (latch_now),
		.live_r      (fer_live),
		.held_r      (fer_hold)
	);

	perf_event_counter #(.W(BW)) u_febe (
		.mclk        (mclk),
		.resetn      (resetn),
		.event_pulse (febe_event),
		.count_ok    (!frame_lost),
		.latch       (latch_now),
		.live_r      (febe_live),
		.held_r      (febe_hold)
	);

	perf_event_counter #(.W(CW)) u_crc (
		.mclk        (mclk),
		.resetn      (resetn),
		.event_pulse (crc_event),
		.count_ok    (!crc_multiframe_lost),
		.latch       (latch_now),
		.live_r      (crc_live),
		.held_r      (crc_hold)
	);

	perf_event_counter #(.W(LW)) u_lcv (
		.mclk        (mclk),
		.resetn      (resetn),
		.event_pulse (lcv_event),
		.count_ok    (1'b1),
		.latch       (latch_now),
		.live_r      (lcv_live),
		.held_r      (lcv_hold)
	);

	// ****************************************************************
	// control/status
	// ****************************************************************
	// a transfer in the same cycle as the acknowledging read wins, so no
	// transfer goes unreported
	assign transfer_done_flag_nxt = latch_now ? 1'b1 :
	                  status_rd ? 1'b0 : transfer_done_flag_r;
	assign ovr_nxt  = (latch_now && transfer_done_flag_r) ? 1'b1 :
	                  status_rd ? 1'b0 : holding_overrun_flag_r;
	// only the enable bit is writable; other bits of the written byte drop
	assign irq_en_nxt = status_wr ? (reg_wdata[perf_monitor_pkg::IRQ_EN_BIT] &&
	                                 irq_supported) :
	                    (irq_on_latch_en_r && irq_supported);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_on_latch_en_r      <= perf_monitor_pkg::IRQ_EN_RST;
			transfer_done_flag_r   <= perf_monitor_pkg::TRANSFER_DONE_FLAG_RST;
			holding_overrun_flag_r <= perf_monitor_pkg::OVR_RST;
		end else begin
			irq_on_latch_en_r      <= irq_en_nxt;
			transfer_done_flag_r   <= transfer_done_flag_nxt;
			holding_overrun_flag_r <= ovr_nxt;
		end
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	// unused bits read as zero; holding values only, never live counts
	assign status_byte = {5'h00, irq_on_latch_en_r, transfer_done_flag_r,
	                      holding_overrun_flag_r};
	always_comb begin
		case (reg_addr)
			perf_monitor_pkg::CTRL_STATUS_ADDR: rdata_nxt = status_byte;
			perf_monitor_pkg::FER_COUNT_ADDR:   rdata_nxt = {1'b0, fer_hold};
			perf_monitor_pkg::FEBE_LOW_ADDR:    rdata_nxt = febe_hold[7:0];
			perf_monitor_pkg::FEBE_HIGH_ADDR:   rdata_nxt = {6'h00, febe_hold[9:8]};
			perf_monitor_pkg::CRC_LOW_ADDR:     rdata_nxt = crc_hold[7:0];
			perf_monitor_pkg::CRC_HIGH_ADDR:    rdata_nxt = {6'h00, crc_hold[9:8]};
			perf_monitor_pkg::LCV_LOW_ADDR:     rdata_nxt = lcv_hold[7:0];
			perf_monitor_pkg::LCV_HIGH_ADDR:    rdata_nxt = {3'h0, lcv_hold[12:8]};
			default:                            rdata_nxt = 8'h00;
		endcase
	end

	// read data holds until the next read strobe
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_r <= perf_monitor_pkg::RDATA_RST;
		end else if (reg_rd) begin
			reg_rdata_r <= rdata_nxt;
		end
	end

	// ****************************************************************
	// interrupt
	// ****************************************************************
	// built from next-state values so the pin moves with the flag itself
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			interrupt_request_n <= 1'b1;
		end else begin
			interrupt_request_n <= !(transfer_done_flag_nxt && irq_en_nxt);
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_latch;
		reg_wr && count_addr;
	endsequence

	sequence s_status_ack;
		reg_rd && (reg_addr == perf_monitor_pkg::CTRL_STATUS_ADDR) && !latch_now;
	endsequence

	chk_fer_suppress: assert property (
		(frame_lost && !latch_now) |=> $stable(fer_live))
		else $error("framing errors counted while unaligned");

	chk_febe_count: assert property (
		(febe_event && !frame_lost && !latch_now && !(&febe_live))
		|=> febe_live == $past(febe_live) + 10'h001)
		else $error("far-end block error not counted");

	chk_crc_suppress: assert property (
		(crc_multiframe_lost && !latch_now) |=> $stable(crc_live))
		else $error("crc errors counted without multiframe alignment");

	chk_lcv_saturate: assert property (
		((&lcv_live) && !latch_now) |=> (&lcv_live))
		else $error("line code violation counter wrapped");

	chk_latch_copy: assert property (
		s_latch |=> (fer_hold == $past(fer_live)) && (lcv_hold == $past(lcv_live)) &&
		            (lcv_live == {12'h000, $past(lcv_event)}))
		else $error("latch did not copy and restart counters");

	chk_latch_bound: assert property (
		s_latch |-> ##[1:LATCH_LIMIT] transfer_done_flag_r)
		else $error("transfer not reported in time");

	chk_read_hold: assert property (
		(reg_rd && reg_addr == perf_monitor_pkg::CRC_LOW_ADDR)
		|=> reg_rdata_r == crc_hold[7:0])
		else $error("count read did not return holding value");

	chk_status_clear: assert property (
		s_status_ack |=> !transfer_done_flag_r && !holding_overrun_flag_r ##1
		                 (interrupt_request_n || transfer_done_flag_r))
		else $error("status read did not clear flags");

	chk_overrun_set: assert property (
		(s_latch and transfer_done_flag_r) |=> holding_overrun_flag_r)
		else $error("overrun not flagged");

	chk_irq_follow: assert property (
		(transfer_done_flag_r && irq_on_latch_en_r) == !interrupt_request_n)
		else $error("interrupt does not follow flag and enable");

	chk_irq_absent: assert property (
		(chip_revision_field == EARLY_REV_ID) |=> !irq_on_latch_en_r && interrupt_request_n)
		else $error("interrupt enable present on early revision");

	chk_fer_count: assert property (
		(fer_event && !frame_lost && !latch_now && !(&fer_live))
		|=> fer_live == $past(fer_live) + 7'h01)
		else $error("framing error not counted");

	chk_crc_count: assert property (
		(crc_event && !crc_multiframe_lost && !latch_now && !(&crc_live))
		|=> crc_live == $past(crc_live) + 10'h001)
		else $error("crc error not counted");

	chk_lcv_count: assert property (
		(lcv_event && !latch_now && !(&lcv_live))
		|=> lcv_live == $past(lcv_live) + 13'h0001)
		else $error("line code violation not counted");

	chk_febe_suppress: assert property (
		(frame_lost && !latch_now) |=> $stable(febe_live))
		else $error("far-end block errors counted while unaligned");

	// holding copies may only move on a latch, so reads see one interval
	chk_hold_stable: assert property (
		!latch_now |=> $stable(fer_hold) && $stable(febe_hold) && $stable(crc_hold) &&
		               $stable(lcv_hold))
		else $error("holding registers moved without a latch");

	chk_enable_set: assert property (
		(status_wr && irq_supported && reg_wdata[perf_monitor_pkg::IRQ_EN_BIT])
		|=> irq_on_latch_en_r)
		else $error("interrupt enable not set by write");

	chk_enable_clear: assert property (
		(status_wr && !reg_wdata[perf_monitor_pkg::IRQ_EN_BIT]) |=> !irq_on_latch_en_r)
		else $error("interrupt enable not cleared by write");

	chk_transfer_done_flag_stable: assert property (
		(!latch_now && !status_rd) |=> $stable(transfer_done_flag_r))
		else $error("transfer flag moved without latch or read");

	chk_ovr_stable: assert property (
		(!latch_now && !status_rd) |=> $stable(holding_overrun_flag_r))
		else $error("overrun flag moved without latch or read");

endmodule : perf_monitor

// ===== bench/perf_monitor_bench.sv
// self-checking bench for the performance-monitor counter block
`timescale 1ns/1ns
module perf_monitor_bench;
	// ****************************************************************
	// signals, rows and checking tasks
	// ****************************************************************
	typedef struct {
		int         n;
		logic       lost;
		logic       mf_lost;
		logic [7:0] addr;
		logic [6:0] framing_bit_error_count;
		logic [9:0] febe;
		logic [9:0] crc;
		logic [12:0] lcv;
	} row_t;
	logic        mclk = 1'b0;
	logic        resetn;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata_r;
	logic        fer_event;
	logic        febe_event;
	logic        crc_event;
	logic        lcv_event;
	logic        frame_lost;
	logic        crc_multiframe_lost;
	logic [6:0]  chip_revision_field;
	logic        interrupt_request_n;
	int          n_mismatch = 0;
	int          check_count = 0;
	// rows walk every count address; 8200 events saturate all four counters
	row_t rows [7] = '{
		'{5, 1'b0, 1'b0, 8'h49, 7'h05, 10'h005, 10'h005, 13'h0005},
		'{6, 1'b1, 1'b0, 8'h4a, 7'h00, 10'h000, 10'h006, 13'h0006},
		'{7, 1'b0, 1'b1, 8'h4b, 7'h07, 10'h007, 10'h000, 13'h0007},
		'{200, 1'b0, 1'b0, 8'h4c, 7'h7f, 10'h0c8, 10'h0c8, 13'h00c8},
		'{1030, 1'b0, 1'b0, 8'h4d, 7'h7f, 10'h3ff, 10'h3ff, 13'h0406},
		'{8200, 1'b0, 1'b0, 8'h4e, 7'h7f, 10'h3ff, 10'h3ff, 13'h1fff},
		'{0, 1'b0, 1'b0, 8'h4f, 7'h00, 10'h000, 10'h000, 13'h0000}};

	// early-revision id handed to the design; the value is arbitrary
	perf_monitor #(.EARLY_REV_ID(7'h2a)) u_perf_monitor (
		.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
		.fer_event(fer_event), .febe_event(febe_event), .crc_event(crc_event),
		.lcv_event(lcv_event), .frame_lost(frame_lost),
		.crc_multiframe_lost(crc_multiframe_lost),
		.chip_revision_field(chip_revision_field),
		.interrupt_request_n(interrupt_request_n));

	always #5 mclk = ~mclk;

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_byte

	task automatic check_irq(input logic exp);
		check_count++;
		if (interrupt_request_n !== exp) begin
			n_mismatch++;
			$display("ERROR %0t interrupt level %b expected %b", $time, interrupt_request_n, exp);
		end
	endtask : check_irq

	// strobes rise and fall on falling edges, so the rising edge sees them settled
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge mclk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask : reg_write

	task automatic read_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
		@(negedge mclk);
		reg_addr = addr;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		check_byte(reg_rdata_r, exp, what);
	endtask : read_check

	task automatic pulse_events(input int n);
		if (n > 0) begin
			@(negedge mclk);
			{fer_event, febe_event, crc_event, lcv_event} = 4'hf;
			repeat (n) @(negedge mclk);
			{fer_event, febe_event, crc_event, lcv_event} = 4'h0;
		end
	endtask : pulse_events

	task automatic check_counts(input logic [6:0] framing_bit_error_count, input logic [9:0] febe,
		input logic [9:0] crc, input logic [12:0] lcv);
		repeat (perf_monitor_pkg::READ_WAIT_CYCLES) @(negedge mclk);
		read_check(8'h49, {1'b0, framing_bit_error_count}, "fer count");
		read_check(8'h4a, febe[7:0], "febe low");
		read_check(8'h4b, {6'h00, febe[9:8]}, "febe high");
		read_check(8'h4c, crc[7:0], "crc low");
		read_check(8'h4d, {6'h00, crc[9:8]}, "crc high");
		read_check(8'h4e, lcv[7:0], "lcv low");
		read_check(8'h4f, {3'h0, lcv[12:8]}, "lcv high");
	endtask : check_counts

	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// watchdog sized well beyond the roughly eleven and a half thousand cycles of the run
	initial begin
		#600000;
		n_mismatch++;
		$display("ERROR %0t watchdog expired", $time);
		end_sim();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{resetn, reg_wr, reg_rd, frame_lost, crc_multiframe_lost} = 5'h00;
		{fer_event, febe_event, crc_event, lcv_event} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		chip_revision_field = 7'h01;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		resetn = 1'b1;
		check_byte(reg_rdata_r, 8'h00, "read data after reset");
		check_irq(1'b1);
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h00, "status after reset");
		// table rows: gated events, latch through each count address
		foreach (rows[i]) begin
			@(negedge mclk);
			frame_lost = rows[i].lost;
			crc_multiframe_lost = rows[i].mf_lost;
			pulse_events(rows[i].n);
			@(negedge mclk);
			{frame_lost, crc_multiframe_lost} = 2'b00;
			reg_write(rows[i].addr, 8'h5a);
			read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h02, "transfer_done_flag");
			check_counts(rows[i].framing_bit_error_count, rows[i].febe, rows[i].crc, rows[i].lcv);
		end
		// live events must not show until the next latch; latch-cycle event kept
		pulse_events(4);
		check_counts(7'h00, 10'h000, 10'h000, 13'h0000);
		@(negedge mclk);
		reg_addr = 8'h4e;
		reg_wr = 1'b1;
		lcv_event = 1'b1;
		@(negedge mclk);
		{reg_wr, lcv_event} = 2'b00;
		check_counts(7'h04, 10'h004, 10'h004, 13'h0004);
		reg_write(8'h49, 8'h00);
		check_counts(7'h00, 10'h000, 10'h000, 13'h0001);
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h03, "overrun");
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h00, "cleared");
		// enable, interrupt, overrun and acknowledge
		reg_write(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'hff);
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h04, "enable only");
		check_irq(1'b1);
		reg_write(8'h4a, 8'h00);
		check_irq(1'b0);
		reg_write(8'h4f, 8'h00);
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h07, "overrun irq");
		check_irq(1'b1);
		// unmapped address and status writes never latch
		reg_write(8'h50, 8'hff);
		reg_write(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h04);
		read_check(8'h50, 8'h00, "unmapped");
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h04, "no latch");
		// disabled enable blocks the interrupt
		reg_write(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h00);
		reg_write(8'h4b, 8'h00);
		check_irq(1'b1);
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h02, "disabled");
		// earliest revision has no enable
		chip_revision_field = 7'h2a;
		reg_write(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h04);
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h00, "early rev");
		reg_write(8'h4c, 8'h00);
		check_irq(1'b1);
		// reset in mid-run with an interrupt pending
		chip_revision_field = 7'h01;
		reg_write(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h04);
		reg_write(8'h4d, 8'h00);
		check_irq(1'b0);
		resetn = 1'b0;
		#1;
		check_irq(1'b1);
		check_byte(reg_rdata_r, 8'h00, "read data in reset");
		@(negedge mclk);
		resetn = 1'b1;
		read_check(perf_monitor_pkg::CTRL_STATUS_ADDR, 8'h00, "second reset");
		end_sim();
	end
endmodule : perf_monitor_bench
